// ---- verilog/rtcsa_pkg.sv ----
// shared constants and types for the rtc serial slave access link
package rtcsa_pkg;
	// ----------------------------------------------------------------
	// bus addressing and storage
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h68; // address byte d0h without direction bit
	localparam int NUM_LOC = 8;
	localparam int PTR_W = 3;
	localparam logic [2:0] PTR_RESET = 3'h0;
	localparam logic [3:0] ACK_BIT = 4'h8; // bit index of the ninth clock
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_KHZ = 50000;
	localparam int F_SCL_KHZ = 100;
	localparam int QUARTER_CYC = SYS_CLK_KHZ / (F_SCL_KHZ * 4);
	localparam int T_REC_US = 10;
	localparam int T_REC_CYC = (T_REC_US * SYS_CLK_KHZ + 999) / 1000;
	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_RX = 3'h1,
		D_RX_ACK = 3'h2,
		D_TX = 3'h3,
		D_TX_ACK = 3'h4
	} rtcsa_dev_state_e;
	typedef enum logic [1:0] {
		K_SLA = 2'h0,
		K_WADDR = 2'h1,
		K_DATA = 2'h2
	} rtcsa_rx_kind_e;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_REC = 3'h1,
		H_START = 3'h2,
		H_BIT = 3'h3,
		H_STOP = 3'h4
	} rtcsa_host_state_e;
	typedef enum logic [2:0] {
		B_SLA_W = 3'h0,
		B_WADDR = 3'h1,
		B_SLA_R = 3'h2,
		B_WDATA = 3'h3,
		B_RDATA = 3'h4
	} rtcsa_byte_kind_e;
endpackage

// ---- verilog/rtcsa_if.sv ----
// two-wire bus between the serial master and the rtc slave
`timescale 1ns/1ps
interface rtcsa_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// wired-and with pull-up: a released line reads high
	assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
	assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface

// ---- verilog/rtcsa_dev.sv ----
// rtc serial slave end: bus decoder, pointer and eight byte locations
`timescale 1ns/1ps
module rtcsa_dev (
	// clocks, reset, enable
	input wire logic link_clk,
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// supply monitor, high while main supply is valid
	input wire logic supply_ok,
	// two-wire bus
	rtcsa_if.dev bus,
	// location update report, sys_clk domain
	output logic upd_strobe,
	output logic [2:0] upd_addr,
	output logic [7:0] upd_data
);
	// ----------------------------------------------------------------
	// link domain synchronisers
	// ----------------------------------------------------------------
	logic rst_l1;
	logic rst_l2;
	logic ce_l1;
	logic ce_l2;
	logic pwr_s1;
	logic pwr_s2;
	logic scl_s1;
	logic scl_s2;
	logic scl_d;
	logic sda_s1;
	logic sda_s2;
	logic sda_d;
	// reset, enable and supply level brought into the link domain
	always_ff @(posedge link_clk) begin
		rst_l1 <= rst;
		rst_l2 <= rst_l1;
		ce_l1 <= ce;
		ce_l2 <= ce_l1;
		pwr_s1 <= supply_ok;
		pwr_s2 <= pwr_s1;
	end

	// bus pins pass two flops; a third stage gives the edge history
	always_ff @(posedge link_clk) begin
		if (rst_l2) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else if (ce_l2) begin
			scl_s1 <= bus.scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	// ----------------------------------------------------------------
	// bus conditions
	// ----------------------------------------------------------------
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic dead;
	// data moving while the clock is high marks start and stop
	assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign dead = ~pwr_s2;

	// ----------------------------------------------------------------
	// byte engine
	// ----------------------------------------------------------------
	rtcsa_pkg::rtcsa_dev_state_e state_reg;
	rtcsa_pkg::rtcsa_rx_kind_e kind_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] sh_reg;
	logic [2:0] ptr_reg;
	logic [2:0] ptr_inc;
	logic sda_low_reg;
	logic ack_seen_reg;
	logic mem_we;
	logic [7:0] mem [rtcsa_pkg::NUM_LOC];

	assign ptr_inc = ptr_reg + 3'h1;

	// store on the ninth clock of a data byte
	assign mem_we = ce_l2 & ~rst_l2 & ~dead & ~start_det & ~stop_det & scl_fall &
		(state_reg == rtcsa_pkg::D_RX_ACK) & (kind_reg == rtcsa_pkg::K_DATA);

	// main protocol sequencer; start and stop override any state
	always_ff @(posedge link_clk) begin
		if (rst_l2) begin
			state_reg <= rtcsa_pkg::D_IDLE;
			kind_reg <= rtcsa_pkg::K_SLA;
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			ptr_reg <= rtcsa_pkg::PTR_RESET;
			sda_low_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else if (ce_l2) begin
			if (dead) begin
				state_reg <= rtcsa_pkg::D_IDLE;
				kind_reg <= rtcsa_pkg::K_SLA;
				bit_cnt_reg <= 4'h0;
				ptr_reg <= rtcsa_pkg::PTR_RESET;
				sda_low_reg <= 1'b0;
			end else if (start_det) begin
				state_reg <= rtcsa_pkg::D_RX;
				kind_reg <= rtcsa_pkg::K_SLA;
				bit_cnt_reg <= 4'h0;
				sda_low_reg <= 1'b0;
			end else if (stop_det) begin
				state_reg <= rtcsa_pkg::D_IDLE;
				sda_low_reg <= 1'b0;
			end else begin
				case (state_reg)
					rtcsa_pkg::D_RX: begin
						if (scl_rise && bit_cnt_reg != rtcsa_pkg::ACK_BIT) begin
							sh_reg <= {sh_reg[6:0], sda_s2};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == rtcsa_pkg::ACK_BIT) begin
							if (kind_reg == rtcsa_pkg::K_SLA && sh_reg[7:1] != rtcsa_pkg::SLAVE_ADDR) begin
								state_reg <= rtcsa_pkg::D_IDLE;
							end else begin
								state_reg <= rtcsa_pkg::D_RX_ACK;
								sda_low_reg <= 1'b1;
							end
						end
					end
					rtcsa_pkg::D_RX_ACK: begin
						if (scl_fall) begin
							sda_low_reg <= 1'b0;
							bit_cnt_reg <= 4'h0;
							case (kind_reg)
								rtcsa_pkg::K_SLA: begin
									if (sh_reg[0]) begin
										state_reg <= rtcsa_pkg::D_TX;
										sh_reg <= mem[ptr_reg];
										sda_low_reg <= ~mem[ptr_reg][7];
									end else begin
										state_reg <= rtcsa_pkg::D_RX;
										kind_reg <= rtcsa_pkg::K_WADDR;
									end
								end
								rtcsa_pkg::K_WADDR: begin
									ptr_reg <= sh_reg[2:0];
									kind_reg <= rtcsa_pkg::K_DATA;
									state_reg <= rtcsa_pkg::D_RX;
								end
								default: begin
									ptr_reg <= ptr_inc;
									state_reg <= rtcsa_pkg::D_RX;
								end
							endcase
						end
					end
					rtcsa_pkg::D_TX: begin
						// bits change only after the clock falls
						if (scl_fall) begin
							if (bit_cnt_reg == rtcsa_pkg::LAST_TX_BIT) begin
								sda_low_reg <= 1'b0;
								state_reg <= rtcsa_pkg::D_TX_ACK;
							end else begin
								sda_low_reg <= ~sh_reg[6];
								sh_reg <= {sh_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
							end
						end
					end
					rtcsa_pkg::D_TX_ACK: begin
						if (scl_rise) begin
							ack_seen_reg <= ~sda_s2;
						end else if (scl_fall) begin
							bit_cnt_reg <= 4'h0;
							if (ack_seen_reg) begin
								ptr_reg <= ptr_inc;
								sh_reg <= mem[ptr_inc];
								sda_low_reg <= ~mem[ptr_inc][7];
								state_reg <= rtcsa_pkg::D_TX;
							end else begin
								state_reg <= rtcsa_pkg::D_IDLE;
							end
						end
					end
					default: begin
						state_reg <= rtcsa_pkg::D_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// byte locations and update report
	// ----------------------------------------------------------------
	logic upd_tgl_reg;
	logic [2:0] upd_addr_l;
	logic [7:0] upd_data_l;
	// no reset on the array: contents are battery backed in the real part
	always_ff @(posedge link_clk) begin
		if (mem_we) begin
			mem[ptr_reg] <= sh_reg;
		end
	end

	// held copy of the last write; stays stable for a whole byte time
	always_ff @(posedge link_clk) begin
		if (rst_l2) begin
			upd_tgl_reg <= 1'b0;
			upd_addr_l <= 3'h0;
			upd_data_l <= 8'h00;
		end else if (mem_we) begin
			upd_tgl_reg <= ~upd_tgl_reg;
			upd_addr_l <= ptr_reg;
			upd_data_l <= sh_reg;
		end
	end

	logic tg_s1;
	logic tg_s2;
	logic tg_s3;
	// toggle crossing; the held words are read only after the edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
			upd_strobe <= 1'b0;
			upd_addr <= 3'h0;
			upd_data <= 8'h00;
		end else if (ce) begin
			tg_s1 <= upd_tgl_reg;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
			upd_strobe <= tg_s2 ^ tg_s3;
			if (tg_s2 ^ tg_s3) begin
				upd_addr <= upd_addr_l;
				upd_data <= upd_data_l;
			end
		end else begin
			upd_strobe <= 1'b0;
		end
	end

	// open drain: only ever pull low
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = ~sda_low_reg;
endmodule // rtcsa_dev

// ---- verilog/rtcsa_host.sv ----
// two-wire bus master that reads and writes the rtc locations
`timescale 1ns/1ps
module rtcsa_host (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// supply level seen by the bus
	input wire logic supply_ok,
	// two-wire bus
	rtcsa_if.host bus,
	// command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic cmd_set_ptr,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	// write data and read data
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// completion
	output logic done,
	output logic nack_err
);
	// ----------------------------------------------------------------
	// pin sync and bit timing
	// ----------------------------------------------------------------
	logic sda_s1;
	logic sda_s2;
	logic pwr_s1;
	logic pwr_s2;
	// external levels pass two flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			pwr_s1 <= 1'b0;
			pwr_s2 <= 1'b0;
		end else if (ce) begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			pwr_s1 <= supply_ok;
			pwr_s2 <= pwr_s1;
		end
	end

	rtcsa_pkg::rtcsa_host_state_e state_reg;
	rtcsa_pkg::rtcsa_byte_kind_e kind_reg;
	logic [8:0] cnt_reg;
	logic [1:0] phase_reg;
	logic tick;
	logic [3:0] bit_cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] len_reg;
	logic [7:0] addr_reg;
	logic rd_reg;
	logic ack_low_reg;
	logic scl_low_reg;
	logic sda_low_reg;
	logic rx_byte;

	// quarter of an scl period: 2.5 us, so low and high are 5 us each
	assign tick = (cnt_reg == 9'(rtcsa_pkg::QUARTER_CYC - 1));
	assign rx_byte = (kind_reg == rtcsa_pkg::B_RDATA);
	assign cmd_ready = (state_reg == rtcsa_pkg::H_IDLE);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= rtcsa_pkg::H_REC;
			kind_reg <= rtcsa_pkg::B_SLA_W;
			cnt_reg <= 9'h000;
			phase_reg <= 2'h0;
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			len_reg <= 8'h00;
			addr_reg <= 8'h00;
			rd_reg <= 1'b0;
			ack_low_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			wr_take <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
		end else if (ce) begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			cnt_reg <= tick ? 9'h000 : cnt_reg + 9'h001;
			if (!pwr_s2) begin
				// restart the recovery wait, lines released
				state_reg <= rtcsa_pkg::H_REC;
				cnt_reg <= 9'h000;
				scl_low_reg <= 1'b0;
				sda_low_reg <= 1'b0;
			end else begin
				case (state_reg)
					rtcsa_pkg::H_REC: begin
						// bus idle high for the recovery time
						if (cnt_reg == 9'(rtcsa_pkg::T_REC_CYC - 1)) begin
							state_reg <= rtcsa_pkg::H_IDLE;
						end else begin
							// the quarter-bit wrap must not cut the recovery count short
							cnt_reg <= cnt_reg + 9'h001;
						end
					end
					rtcsa_pkg::H_IDLE: begin
						cnt_reg <= 9'h000;
						phase_reg <= 2'h0;
						if (cmd_valid) begin
							nack_err <= 1'b0;
							rd_reg <= cmd_read;
							addr_reg <= cmd_addr;
							len_reg <= (cmd_read && cmd_len == 8'h00) ? 8'h01 : cmd_len;
							// plain read skips the pointer load
							kind_reg <= (cmd_read && !cmd_set_ptr) ? rtcsa_pkg::B_SLA_R
								: rtcsa_pkg::B_SLA_W;
							state_reg <= rtcsa_pkg::H_START;
						end
					end
					rtcsa_pkg::H_START: begin
						if (tick) begin
							phase_reg <= phase_reg + 2'h1;
							case (phase_reg)
								2'h0: sda_low_reg <= 1'b0;
								2'h1: scl_low_reg <= 1'b0;
								2'h2: sda_low_reg <= 1'b1;
								default: begin
									scl_low_reg <= 1'b1;
									sh_reg <= {rtcsa_pkg::SLAVE_ADDR, kind_reg == rtcsa_pkg::B_SLA_R};
									bit_cnt_reg <= 4'h0;
									state_reg <= rtcsa_pkg::H_BIT;
								end
							endcase
						end
					end
					rtcsa_pkg::H_BIT: begin
						if (tick) begin
							phase_reg <= phase_reg + 2'h1;
							case (phase_reg)
								2'h0: begin
									if (bit_cnt_reg != rtcsa_pkg::ACK_BIT) begin
										sda_low_reg <= rx_byte ? 1'b0 : ~sh_reg[7];
									end else begin
										// ack all but the last read byte
										sda_low_reg <= rx_byte && len_reg != 8'h01;
									end
								end
								2'h1: scl_low_reg <= 1'b0;
								2'h2: begin
									if (bit_cnt_reg != rtcsa_pkg::ACK_BIT) begin
										sh_reg <= {sh_reg[6:0], sda_s2};
									end else begin
										ack_low_reg <= ~sda_s2;
									end
								end
								default: begin
									scl_low_reg <= 1'b1;
									bit_cnt_reg <= bit_cnt_reg + 4'h1;
									if (bit_cnt_reg == rtcsa_pkg::ACK_BIT) begin
										bit_cnt_reg <= 4'h0;
										state_reg <= rtcsa_pkg::H_BIT;
										if (!rx_byte && !ack_low_reg) begin
											nack_err <= 1'b1;
											state_reg <= rtcsa_pkg::H_STOP;
										end else begin
											case (kind_reg)
												rtcsa_pkg::B_SLA_W: begin
													kind_reg <= rtcsa_pkg::B_WADDR;
													sh_reg <= addr_reg;
												end
												rtcsa_pkg::B_WADDR: begin
													if (rd_reg) begin
														kind_reg <= rtcsa_pkg::B_SLA_R;
														state_reg <= rtcsa_pkg::H_START;
													end else if (len_reg != 8'h00) begin
														kind_reg <= rtcsa_pkg::B_WDATA;
														sh_reg <= wr_data;
														wr_take <= 1'b1;
														len_reg <= len_reg - 8'h01;
													end else begin
														state_reg <= rtcsa_pkg::H_STOP;
													end
												end
												rtcsa_pkg::B_SLA_R: begin
													kind_reg <= rtcsa_pkg::B_RDATA;
												end
												rtcsa_pkg::B_WDATA: begin
													if (len_reg != 8'h00) begin
														sh_reg <= wr_data;
														wr_take <= 1'b1;
														len_reg <= len_reg - 8'h01;
													end else begin
														state_reg <= rtcsa_pkg::H_STOP;
													end
												end
												default: begin
													rd_data <= sh_reg;
													rd_valid <= 1'b1;
													len_reg <= len_reg - 8'h01;
													// stop after the last read byte
													if (len_reg == 8'h01) begin
														state_reg <= rtcsa_pkg::H_STOP;
													end
												end
											endcase
										end
									end
								end
							endcase
						end
					end
					rtcsa_pkg::H_STOP: begin
						if (tick) begin
							phase_reg <= phase_reg + 2'h1;
							case (phase_reg)
								2'h0: sda_low_reg <= 1'b1;
								2'h1: scl_low_reg <= 1'b0;
								2'h2: sda_low_reg <= 1'b0;
								default: begin
									done <= 1'b1;
									state_reg <= rtcsa_pkg::H_IDLE;
								end
							endcase
						end
					end
					default: state_reg <= rtcsa_pkg::H_IDLE;
				endcase
			end
		end
	end

	// open drain drive of both lines
	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe_n = ~scl_low_reg;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = ~sda_low_reg;
endmodule // rtcsa_host

// ---- verification/rtcsa_assertions.sv ----
// bus-level checks on the two-wire link between master and rtc slave
`timescale 1ns/1ps
module rtcsa_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// slave supply
	input wire logic supply_ok,
	// two-wire bus
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n
);
	logic scl_q_reg;
	logic sda_q_reg;
	logic first_reg;
	logic rw_reg;
	logic rel_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] sh_reg;
	int rec_cnt_reg;
	logic start_ev;
	logic rise_ev;
	logic ack_ev;
	// bus events; sys_clk is far faster than the bus, so sampling suffices
	assign start_ev = scl && scl_q_reg && sda_q_reg && !sda;
	assign rise_ev = scl && !scl_q_reg;
	assign ack_ev = rise_ev && (bit_cnt_reg == rtcsa_pkg::ACK_BIT);
	// line history
	always_ff @(posedge sys_clk) begin
		scl_q_reg <= scl;
		sda_q_reg <= sda;
	end
	// bit and byte tracking, restarted by every start
	always_ff @(posedge sys_clk) begin
		if (rst || start_ev) begin
			bit_cnt_reg <= 4'h0;
			first_reg <= 1'b1;
			rel_reg <= 1'b0;
		end else if (ack_ev) begin
			bit_cnt_reg <= 4'h0;
			first_reg <= 1'b0;
			if (first_reg)
				rw_reg <= sh_reg[0];
			if (!first_reg && rw_reg && sda)
				rel_reg <= 1'b1;
		end else if (rise_ev) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
			sh_reg <= {sh_reg[6:0], sda};
		end
	end
	// cycles since reset release or supply return, saturating
	always_ff @(posedge sys_clk) begin
		if (rst || !supply_ok)
			rec_cnt_reg <= 0;
		else if (rec_cnt_reg < rtcsa_pkg::T_REC_CYC)
			rec_cnt_reg <= rec_cnt_reg + 1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_addr_ack;
		ack_ev && first_reg && (sh_reg[7:1] == rtcsa_pkg::SLAVE_ADDR);
	endsequence
	sequence s_supply_gone;
		!supply_ok [*8];
	endsequence
	sequence s_scl_held;
		scl && scl_q_reg;
	endsequence
	chk_addr_ack: assert property (s_addr_ack ##0 supply_ok |-> !dev_sda_oe_n && !sda)
		else $error("slave address not acknowledged");
	chk_off_nack: assert property (s_addr_ack ##0 !supply_ok |-> dev_sda_oe_n)
		else $error("address acknowledged without supply");
	chk_off_release: assert property (s_supply_gone |-> dev_sda_oe_n)
		else $error("data line driven without supply");
	chk_data_ack: assert property (ack_ev && !first_reg && !rw_reg && supply_ok |-> !sda)
		else $error("received byte not acknowledged");
	chk_dev_steady: assert property (s_scl_held |-> $stable(dev_sda_oe_n))
		else $error("slave changed data line while clock high");
	chk_nack_release: assert property (rel_reg |-> dev_sda_oe_n)
		else $error("slave drove data line after master nack");
	chk_rec_idle: assert property (supply_ok && rec_cnt_reg < rtcsa_pkg::T_REC_CYC |->
		scl && sda)
		else $error("bus used before recovery time");
	chk_rx_quiet: assert property (rise_ev && (first_reg || !rw_reg) &&
		bit_cnt_reg != rtcsa_pkg::ACK_BIT |-> dev_sda_oe_n)
		else $error("slave drove data line while receiving");
endmodule // rtcsa_assertions

// ---- verification/rtcsa_tb.sv ----
// self-checking bench: master and rtc slave joined on one two-wire bus
`timescale 1ns/1ps
module rtcsa_tb;
	typedef struct packed {
		logic is_rd;
		logic [2:0] addr;
		logic [7:0] data;
	} rtcsa_exp_s;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic dev_supply = 1'b1;
	logic host_supply = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic cmd_set_ptr = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_take, rd_valid, done, nack_err, upd_strobe;
	logic [7:0] rd_data;
	logic [7:0] upd_data;
	logic [2:0] upd_addr;
	logic [7:0] mem_m [8];
	logic [2:0] ptr_m = 3'h0;
	bit took_q = 1'b0;
	rtcsa_exp_s exp_q [$];
	logic [7:0] wr_q [$];
	int err_total = 0;
	int checks_done = 0;
	// ----------------------------------------------------------------
	// design, bus and checker
	// ----------------------------------------------------------------
	rtcsa_if bus_if ();
	rtcsa_dev i_rtcsa_dev (.link_clk(link_clk), .sys_clk(sys_clk), .rst(rst), .ce(ce),
		.supply_ok(dev_supply), .bus(bus_if), .upd_strobe(upd_strobe), .upd_addr(upd_addr),
		.upd_data(upd_data));
	rtcsa_host i_rtcsa_host (.sys_clk(sys_clk), .rst(rst), .ce(ce), .supply_ok(host_supply),
		.bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_set_ptr(cmd_set_ptr), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
		.wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
		.nack_err(nack_err));
	rtcsa_assertions i_rtcsa_assertions (.sys_clk(sys_clk), .rst(rst), .supply_ok(dev_supply),
		.scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_o(bus_if.dev_sda_o),
		.dev_sda_oe_n(bus_if.dev_sda_oe_n));
	// system clock, 50 MHz
	always #10 sys_clk = ~sys_clk;
	// link clock, 6 ns, offset so its edges never meet sys_clk edges
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// notes the expected results, then issues one command and waits for done
	task automatic run_cmd(input string name, input logic rd, input logic sp,
		input logic [2:0] addr, input int len, input logic exp_nack);
		int n;
		logic [7:0] d;
		n = (rd && len == 0) ? 1 : len;
		if (!rd || sp)
			ptr_m = addr;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			if (rd) begin
				exp_q.push_back({1'b1, 3'h0, mem_m[ptr_m]});
			end else begin
				wr_q.push_back(d);
				exp_q.push_back({1'b0, ptr_m, d});
				mem_m[ptr_m] = d;
			end
			// the final read byte is nacked, so the pointer stays on it
			if (!rd || i < n - 1)
				ptr_m = ptr_m + 3'h1;
		end
		if (exp_nack)
			ptr_m = 3'h0;
		wr_data = (wr_q.size() != 0) ? wr_q[0] : 8'h00;
		cmd_read = rd;
		cmd_set_ptr = sp;
		cmd_addr = {5'h00, addr};
		cmd_len = 8'(len);
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1)
			@(negedge sys_clk);
		chk({name, " nack"}, {11'h000, exp_nack}, {11'h000, nack_err});
		chk({name, " left"}, 12'h000, 12'(exp_q.size()));
		wr_q.delete();
		$display("test %s done", name);
	endtask
	// next write byte is presented one cycle after the master took the current one
	always @(negedge sys_clk) begin
		if (took_q) begin
			void'(wr_q.pop_front());
			wr_data = (wr_q.size() != 0) ? wr_q[0] : 8'h00;
		end
		took_q = (wr_take === 1'b1);
	end
	// compare every reported result against the oldest note
	always @(negedge sys_clk) begin
		if (rd_valid === 1'b1 || upd_strobe === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unexpected result", 12'h000, 12'hfff);
			else
				chk("result", exp_q.pop_front(), (rd_valid === 1'b1) ?
					{1'b1, 3'h0, rd_data} : {1'b0, upd_addr, upd_data});
		end
	end
	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		void'($urandom(72));
		run_cmd("write_wrap", 1'b0, 1'b0, 3'h7, 2, 1'b0);
		dev_supply = 1'b0;
		repeat (20) @(negedge sys_clk);
		run_cmd("supply_off", 1'b0, 1'b0, 3'h3, 0, 1'b1);
		// the master sees the dip too, so it waits out the recovery time
		dev_supply = 1'b1;
		host_supply = 1'b0;
		repeat (20) @(negedge sys_clk);
		host_supply = 1'b1;
		run_cmd("plain_after_off", 1'b1, 1'b0, 3'h0, 1, 1'b0);
		run_cmd("set_ptr_read", 1'b1, 1'b1, 3'h7, 2, 1'b0);
		run_cmd("plain_read", 1'b1, 1'b0, 3'h0, 1, 1'b0);
		close_out();
	end
	// hang guard: the five transfers need roughly 70000 cycles
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		$display("ERROR watchdog expected done seen timeout");
		close_out();
	end
endmodule // rtcsa_tb
